// file: verilog/front_panel_control.sv
`timescale 1ns/1ns
module front_panel_control
  import panel_pkg::*;
#(
  parameter int unsigned DEB_CYC = DEBOUNCE_CYC,
  parameter int unsigned SPIN_CYC = SPIN_GAP_CYC,
  parameter int NUM_SYNTH = 3
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic [NUM_KEYS-1:0] key_down,
  input wire logic enc_a,
  input wire logic enc_b,
  input wire logic [NUM_SYNTH-1:0] synth_unlock,
  output mode_t mode,
  output logic [2:0] filter_sel,
  output logic split_upper,
  output logic meter_af,
  output logic manual_gain,
  output agc_t agc_mode,
  output rate_t tune_rate,
  output logic tune_lock,
  output logic beat_osc_tune,
  output logic beat_osc_centred,
  output logic remote_ctl,
  output logic entry_active,
  output logic [24:0] freq_hz,
  output logic signed [15:0] beat_osc_hz,
  output logic beat_osc_below,
  output logic fault_lamp
);

  localparam int DW = $clog2(DEB_CYC + 1);
  localparam int GW = $clog2(SPIN_CYC + 1);

  mode_t mode_r, mode_nxt;
  agc_t agc_r, agc_nxt;
  rate_t rate_r, rate_nxt;
  logic [2:0] bw_r, bw_nxt, filter_r, filter_nxt;
  logic upper_r, upper_nxt, meter_r, meter_nxt;
  logic man_r, man_nxt, lock_r, lock_nxt;
  logic btune_r, btune_nxt, centre_r, centre_nxt;
  logic remote_r, remote_nxt, entry_r, entry_nxt;
  logic [3:0] idx_r, idx_nxt;
  logic [24:0] acc_r, acc_nxt, freq_r, freq_nxt;
  logic signed [15:0] beat_r, beat_nxt, saved_r, saved_nxt;
  logic [31:0] cfg_r, hrdata_r;
  logic wr_cfg_r, fault_r, enc_a_q;
  logic [GW-1:0] gap_r;
  logic [NUM_KEYS-1:0] press;

  // per-key debounce; a held key yields one pulse
  for (genvar g = 0; g < NUM_KEYS; g++) begin : deb
    logic [DW-1:0] cnt_r;
    logic lvl_r, pr_r;
    wire settle = cnt_r == DW'(DEB_CYC - 1);
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        cnt_r <= '0;
        lvl_r <= 1'b0;
        pr_r <= 1'b0;
      end else begin
        cnt_r <= (key_down[g] == lvl_r || settle) ? '0 : cnt_r + 1'b1;
        if (settle) lvl_r <= key_down[g];
        pr_r <= settle && key_down[g] && !lvl_r;
      end
    end
    assign press[g] = pr_r;
  end

  // remote blocks the panel even with no remote card fitted
  wire [NUM_KEYS-1:0] kp = remote_r ? '0 : press;

  wire cfg_split = cfg_r[CFG_SPLIT_BIT];
  wire [2:0] sym_cnt = cfg_r[CFG_SYMCNT_LSB +: 3];
  wire in_cw = mode_r == MODE_CONT_WAVE;

  // encoder: rising edge of channel a is one detent
  wire step = enc_a && !enc_a_q;
  wire clockwise = !enc_b;
  wire fast_spin = gap_r < GW'(SPIN_CYC);
  wire [16:0] base_step = (rate_r == RATE_FAST) ? STEP_FAST_HZ :
                          (rate_r == RATE_SLOW) ? STEP_SLOW_HZ : STEP_FINE_HZ;
  wire [16:0] delta = fast_spin ? (base_step << SPIN_SHIFT) : base_step;
  wire enc_ok = step && !lock_r && !remote_r;

  // decimal weight of each entry position, tens of MHz first
  function automatic logic [24:0] place(input logic [3:0] i);
    unique case (i)
      4'h0: place = 25'h0989680;
      4'h1: place = 25'h00F4240;
      4'h2: place = 25'h00186A0;
      4'h3: place = 25'h0002710;
      4'h4: place = 25'h00003E8;
      4'h5: place = 25'h0000064;
      4'h6: place = 25'h000000A;
      default: place = 25'h0000001;
    endcase
  endfunction : place

  logic dig_hit;
  logic [3:0] dig_val;
  always_comb begin
    dig_hit = 1'b0;
    dig_val = 4'h0;
    for (int i = 0; i < 10; i++) begin
      if (kp[K_DIGIT0 + i]) begin
        dig_hit = 1'b1;
        dig_val = 4'(i);
      end
    end
  end

  wire dig_ok = entry_r && dig_hit && idx_r < 4'(ENTRY_DIGITS)
                && (idx_r != 4'h0 || dig_val <= 4'h2);
  wire [31:0] dig_prod = 32'(dig_val) * 32'(place(idx_r));
  wire [25:0] f_up = {1'b0, freq_r} + 26'(delta);
  wire [24:0] f_dn = (freq_r < 25'(delta)) ? 25'h0 : freq_r - 25'(delta);
  wire signed [17:0] b_up = 18'(beat_r) + 18'(delta);
  wire signed [17:0] b_dn = 18'(beat_r) - 18'(delta);
  wire signed [17:0] b_lim = BEAT_OSC_LIMIT;

  // key and encoder decode; later statements win on a clash
  always_comb begin
    mode_nxt = mode_r;
    upper_nxt = upper_r;
    bw_nxt = bw_r;
    meter_nxt = meter_r;
    man_nxt = man_r;
    agc_nxt = agc_r;
    rate_nxt = rate_r;
    lock_nxt = lock_r;
    btune_nxt = btune_r;
    centre_nxt = centre_r;
    beat_nxt = beat_r;
    saved_nxt = saved_r;
    freq_nxt = freq_r;
    entry_nxt = entry_r;
    idx_nxt = idx_r;
    acc_nxt = acc_r;
    remote_nxt = remote_r;
    if (kp[K_AMPLITUDE]) mode_nxt = MODE_AMPLITUDE;
    if (kp[K_CONT_WAVE]) mode_nxt = MODE_CONT_WAVE;
    if (kp[K_UPPER_SB]) mode_nxt = MODE_UPPER_SB;
    if (kp[K_LOWER_SB]) mode_nxt = MODE_LOWER_SB;
    if (kp[K_FREQ_MOD]) mode_nxt = MODE_FREQ_MOD;
    if (kp[K_SPLIT] && cfg_split) begin
      if (mode_r == MODE_INDEP_SB) begin
        upper_nxt = !upper_r;
      end else begin
        mode_nxt = MODE_INDEP_SB;
        upper_nxt = 1'b1;
      end
    end
    for (int i = 0; i < MAX_SYM_FILTERS; i++) begin
      if (kp[K_NARROWEST_FILTER + i] && 3'(i) < sym_cnt) bw_nxt = 3'(i);
    end
    if (kp[K_METER_SCALE]) meter_nxt = !meter_r;
    if (kp[K_MANUAL_GAIN]) begin
      if (man_r && agc_r == AGC_NONE) begin
        man_nxt = 1'b0;
        agc_nxt = AGC_SHORT;
      end else begin
        man_nxt = !man_r;
      end
    end
    for (int i = 0; i < 3; i++) begin
      if (kp[K_SHORT_AGC + i]) begin
        if (man_r && agc_r == agc_t'(2'(i + 1))) agc_nxt = AGC_NONE;
        else agc_nxt = agc_t'(2'(i + 1));
      end
    end
    if (kp[K_TUNE_RATE]) begin
      unique case (rate_r)
        RATE_FINE: rate_nxt = RATE_SLOW;
        RATE_SLOW: rate_nxt = RATE_FAST;
        RATE_FAST: rate_nxt = RATE_FINE;
        default: rate_nxt = RATE_FINE;
      endcase
      lock_nxt = 1'b0;
      btune_nxt = 1'b0;
    end
    if (kp[K_LOCK]) lock_nxt = 1'b1;
    if (kp[K_BEAT_OSC] && in_cw && !centre_r) begin
      btune_nxt = 1'b1;
      lock_nxt = 1'b0;
    end
    if (kp[K_BEAT_OSC_CENTRE] && in_cw) begin
      centre_nxt = !centre_r;
      if (!centre_r) begin
        saved_nxt = beat_r;
        beat_nxt = 16'sh0000;
      end else begin
        beat_nxt = saved_r;
      end
    end
    // encoder goes to the beat offset or the frequency, never both
    if (enc_ok && btune_r && in_cw && !centre_r) begin
      if (clockwise) beat_nxt = 16'((b_up > b_lim) ? b_lim : b_up);
      else beat_nxt = 16'((b_dn < -b_lim) ? -b_lim : b_dn);
    end else if (enc_ok && !btune_r) begin
      if (clockwise) freq_nxt = (f_up > 26'(FREQ_MAX)) ? FREQ_MAX : f_up[24:0];
      else freq_nxt = f_dn;
    end
    if (dig_ok) begin
      acc_nxt = acc_r + dig_prod[24:0];
      idx_nxt = idx_r + 4'h1;
    end
    // second entry press commits whatever digits were given
    if (kp[K_ENTER]) begin
      if (!entry_r) begin
        entry_nxt = 1'b1;
        idx_nxt = 4'h0;
        acc_nxt = 25'h0;
      end else begin
        entry_nxt = 1'b0;
        if (idx_r != 4'h0) freq_nxt = acc_r;
      end
    end
    if (press[K_LOCAL_REMOTE]) remote_nxt = !remote_r;
  end

  // upper and lower sideband modes force their own filter; others, independent sideband included, take the bw key
  assign filter_nxt = (mode_nxt == MODE_UPPER_SB) ? FILT_UPPER_SB :
                      (mode_nxt == MODE_LOWER_SB) ? FILT_LOWER_SB :
                      FILT_SYM_BASE + bw_nxt;

  // operating state
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mode_r <= MODE_AMPLITUDE;
      upper_r <= 1'b1;
      bw_r <= 3'h0;
      filter_r <= FILT_SYM_BASE;
      meter_r <= 1'b0;
      man_r <= 1'b0;
      agc_r <= AGC_SHORT;
      rate_r <= RATE_FINE;
      lock_r <= 1'b0;
      btune_r <= 1'b0;
      centre_r <= 1'b0;
    end else begin
      mode_r <= mode_nxt;
      upper_r <= upper_nxt;
      bw_r <= bw_nxt;
      filter_r <= filter_nxt;
      meter_r <= meter_nxt;
      man_r <= man_nxt;
      agc_r <= agc_nxt;
      rate_r <= rate_nxt;
      lock_r <= lock_nxt;
      btune_r <= btune_nxt;
      centre_r <= centre_nxt;
    end
  end

  // tuning values, entry and encoder history
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      freq_r <= FREQ_RESET;
      beat_r <= 16'sh0000;
      saved_r <= 16'sh0000;
      entry_r <= 1'b0;
      idx_r <= 4'h0;
      acc_r <= 25'h0;
      remote_r <= 1'b0;
      enc_a_q <= 1'b0;
      gap_r <= '0;
      fault_r <= 1'b0;
    end else begin
      freq_r <= freq_nxt;
      beat_r <= beat_nxt;
      saved_r <= saved_nxt;
      entry_r <= entry_nxt;
      idx_r <= idx_nxt;
      acc_r <= acc_nxt;
      remote_r <= remote_nxt;
      enc_a_q <= enc_a;
      // saturating gap timer sizes the spin speed
      gap_r <= step ? '0 : (fast_spin ? gap_r + 1'b1 : gap_r);
      fault_r <= |synth_unlock;
    end
  end

  // ahb-lite slave: zero wait states, always okay
  wire bus_take = hsel && hready && htrans[1];
  wire [31:0] status_word = {13'h0, fault_r, entry_r, remote_r, centre_r,
                             btune_r, lock_r, rate_r, agc_r, man_r, meter_r,
                             upper_r, filter_r, mode_r};
  wire [31:0] read_word = (haddr == ADDR_CONFIG) ? cfg_r :
                          (haddr == ADDR_STATUS) ? status_word :
                          (haddr == ADDR_FREQ) ? {7'h0, freq_r} :
                          (haddr == ADDR_BEAT_OSC) ? 32'(beat_r) : 32'h0;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_r <= 32'h0;
      wr_cfg_r <= 1'b0;
      cfg_r <= CFG_RESET;
    end else begin
      hrdata_r <= (bus_take && !hwrite) ? read_word : 32'h0;
      wr_cfg_r <= bus_take && hwrite && haddr == ADDR_CONFIG;
      if (wr_cfg_r) cfg_r <= hwdata & CFG_MASK;
    end
  end

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = hrdata_r;
  assign mode = mode_r;
  assign filter_sel = filter_r;
  assign split_upper = upper_r;
  assign meter_af = meter_r;
  assign manual_gain = man_r;
  assign agc_mode = agc_r;
  assign tune_rate = rate_r;
  assign tune_lock = lock_r;
  assign beat_osc_tune = btune_r;
  assign beat_osc_centred = centre_r;
  assign remote_ctl = remote_r;
  assign entry_active = entry_r;
  assign freq_hz = freq_r;
  assign beat_osc_hz = beat_r;
  assign beat_osc_below = beat_r[15];
  assign fault_lamp = fault_r;

  // checks
  property p_mode_latch;
    @(posedge hclk) disable iff (!hresetn)
    kp == (32'h1 << K_CONT_WAVE) |=> mode_r == MODE_CONT_WAVE ##1 $stable(mode_r) || $past(kp) != '0;
  endproperty
  a_mode_latch: assert property (p_mode_latch) else $error("mode key not latched");

  property p_split_absent;
    @(posedge hclk) disable iff (!hresetn)
    kp == (32'h1 << K_SPLIT) && !cfg_split |=> $stable(mode_r);
  endproperty
  a_split_absent: assert property (p_split_absent) else $error("split key acted");

  property p_split_swap;
    @(posedge hclk) disable iff (!hresetn)
    kp[K_SPLIT] && cfg_split && mode_r == MODE_INDEP_SB |=> upper_r != $past(upper_r);
  endproperty
  a_split_swap: assert property (p_split_swap) else $error("split did not swap");

  property p_sb_filter;
    @(posedge hclk) disable iff (!hresetn)
    mode_r == MODE_LOWER_SB |-> filter_r == FILT_LOWER_SB;
  endproperty
  a_sb_filter: assert property (p_sb_filter) else $error("wrong sideband filter");

  property p_meter;
    @(posedge hclk) disable iff (!hresetn)
    kp[K_METER_SCALE] |=> meter_r != $past(meter_r);
  endproperty
  a_meter: assert property (p_meter) else $error("meter not toggled");

  property p_man_short;
    @(posedge hclk) disable iff (!hresetn)
    kp == (32'h1 << K_MANUAL_GAIN) && man_r && agc_r == AGC_NONE
      |=> !man_r && agc_r == AGC_SHORT;
  endproperty
  a_man_short: assert property (p_man_short) else $error("manual exit wrong");

  property p_first_digit;
    @(posedge hclk) disable iff (!hresetn)
    entry_r && idx_r == 4'h0 && kp == (32'h1 << (K_DIGIT0 + 3)) |=> idx_r == 4'h0;
  endproperty
  a_first_digit: assert property (p_first_digit) else $error("digit 3 accepted");

  property p_lock;
    @(posedge hclk) disable iff (!hresetn)
    lock_r && kp == '0 |=> $stable(freq_r) && $stable(beat_r);
  endproperty
  a_lock: assert property (p_lock) else $error("tuned while locked");

  property p_centre;
    @(posedge hclk) disable iff (!hresetn)
    kp == (32'h1 << K_BEAT_OSC_CENTRE) && in_cw && !centre_r
      |=> beat_r == 16'sh0000 && centre_r;
  endproperty
  a_centre: assert property (p_centre) else $error("centre did not zero");

  property p_fault;
    @(posedge hclk) disable iff (!hresetn)
    synth_unlock != '0 |=> fault_lamp;
  endproperty
  a_fault: assert property (p_fault) else $error("fault lamp dark");

  property p_one_pulse;
    @(posedge hclk) disable iff (!hresetn)
    press[K_LOCK] |=> !press[K_LOCK];
  endproperty
  a_one_pulse: assert property (p_one_pulse) else $error("double press pulse");

endmodule : front_panel_control

// file: verilog/panel_pkg.sv
// Summary of operation
// - mode keys latch until another mode key
// - split key needs option; enables both sidebands
// - further split presses swap upper/lower routing
// - seven filters; upper/lower sideband modes pick sideband filter
// - filter keys map symmetric filters, narrowest first
// - meter key toggles RF/AF, one always shown
// - manual toggles; manual plus shown auto clears
// - manual alone pressed gives short auto gain
// - auto with manual gives combined threshold state
// - steps are 1 Hz, 30 Hz, 1 kHz
// - clockwise raises, speed and step set rate
// - digits only after entry key, tens MHz first
// - first digit only 0, 1 or 2
// - entry valid with fewer digits
// - lock stops encoder; rate or beat key unlocks
// - beat keys work only in continuous wave
// - beat key steers encoder to beat offset
// - centre zeroes offset, second press restores
// - beat key ignored while centred
// - remote toggles, blocks panel even without option
// - fault lamp on any synthesizer unlock
// - beat readout gives offset with sign
// - no rate flags shown means fine step
package panel_pkg;
  localparam int unsigned CLK_HZ = 50_000_000;
  localparam int unsigned DEBOUNCE_MS = 10;
  localparam int unsigned DEBOUNCE_CYC = DEBOUNCE_MS * (CLK_HZ / 1000);
  localparam int unsigned SPIN_GAP_MS = 5;
  localparam int unsigned SPIN_GAP_CYC = SPIN_GAP_MS * (CLK_HZ / 1000);
  localparam int NUM_KEYS = 32;
  localparam int K_AMPLITUDE = 0;
  localparam int K_CONT_WAVE = 1;
  localparam int K_UPPER_SB = 2;
  localparam int K_LOWER_SB = 3;
  localparam int K_SPLIT = 4;
  localparam int K_FREQ_MOD = 5;
  localparam int K_NARROWEST_FILTER = 6;
  localparam int K_METER_SCALE = 11;
  localparam int K_MANUAL_GAIN = 12;
  localparam int K_SHORT_AGC = 13;
  localparam int K_TUNE_RATE = 16;
  localparam int K_DIGIT0 = 17;
  localparam int K_ENTER = 27;
  localparam int K_LOCK = 28;
  localparam int K_BEAT_OSC = 29;
  localparam int K_BEAT_OSC_CENTRE = 30;
  localparam int K_LOCAL_REMOTE = 31;
  localparam int MAX_FILTERS = 7;
  localparam int MAX_SYM_FILTERS = 5;
  localparam int ENTRY_DIGITS = 8;
  localparam logic [16:0] STEP_FINE_HZ = 17'h00001;
  localparam logic [16:0] STEP_SLOW_HZ = 17'h0001E;
  localparam logic [16:0] STEP_FAST_HZ = 17'h003E8;
  localparam int SPIN_SHIFT = 3;
  localparam logic [24:0] FREQ_MAX = 25'h1C9C37F;
  localparam logic [24:0] FREQ_RESET = 25'h0000000;
  localparam logic [17:0] BEAT_OSC_LIMIT = 18'h02710;
  localparam logic [2:0] FILT_UPPER_SB = 3'h0;
  localparam logic [2:0] FILT_LOWER_SB = 3'h1;
  localparam logic [2:0] FILT_SYM_BASE = 3'h2;
  localparam logic [31:0] ADDR_CONFIG = 32'h00000000;
  localparam logic [31:0] ADDR_STATUS = 32'h00000004;
  localparam logic [31:0] ADDR_FREQ = 32'h00000008;
  localparam logic [31:0] ADDR_BEAT_OSC = 32'h0000000C;
  localparam int CFG_SPLIT_BIT = 0;
  localparam int CFG_REMOTE_BIT = 1;
  localparam int CFG_SYMCNT_LSB = 4;
  localparam logic [31:0] CFG_MASK = 32'h00000073;
  localparam logic [31:0] CFG_RESET = 32'h00000050;
  typedef enum logic [2:0] {
    MODE_AMPLITUDE = 3'h0, MODE_CONT_WAVE = 3'h1, MODE_UPPER_SB = 3'h2,
    MODE_LOWER_SB = 3'h3, MODE_INDEP_SB = 3'h4, MODE_FREQ_MOD = 3'h5
  } mode_t;
  typedef enum logic [1:0] {
    AGC_NONE = 2'h0, AGC_SHORT = 2'h1, AGC_MEDIUM = 2'h2, AGC_LONG = 2'h3
  } agc_t;
  typedef enum logic [1:0] {
    RATE_FINE = 2'h0, RATE_SLOW = 2'h1, RATE_FAST = 2'h2
  } rate_t;
endpackage : panel_pkg

// file: bench/panel_model.sv
`timescale 1ns/1ns
module panel_model
  import panel_pkg::*;
(
  output logic [NUM_KEYS-1:0] key_down,
  output logic enc_a,
  output logic enc_b,
  input wire logic hclk
);
  // all keys up, knob at rest
  initial begin
    key_down = '0;
    enc_a = 1'b0;
    enc_b = 1'b0;
  end
  // release gap is kept longer than the key filter span
  task automatic press(input int k, input int hold);
    @(posedge hclk);
    key_down[k] <= 1'b1;
    repeat (hold) @(posedge hclk);
    key_down[k] <= 1'b0;
    repeat (8) @(posedge hclk);
  endtask : press
  // one detent; phase b low at the rising a edge means clockwise
  task automatic turn(input logic cw, input int gap);
    @(posedge hclk);
    enc_b <= ~cw;
    repeat (2) @(posedge hclk);
    enc_a <= 1'b1;
    repeat (2) @(posedge hclk);
    enc_a <= 1'b0;
    enc_b <= 1'b0;
    repeat (gap) @(posedge hclk);
  endtask : turn
endmodule : panel_model

// file: bench/receiver_front_panel_control_test.sv
`timescale 1ns/1ns
`define CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin err_total++; \
  $display("[FAIL] %0t mismatch got %0h exp %0h", $time, got, exp); end end
module receiver_front_panel_control_test
  import panel_pkg::*;
;
  typedef struct {int k; logic [18:0] m; logic [18:0] e;} row_t;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic [31:0] haddr = 32'h00000000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h00000000;
  logic [2:0] synth_unlock = 3'h0;
  logic hreadyout, hresp, enc_a, enc_b;
  logic [31:0] hrdata, rd;
  logic [NUM_KEYS-1:0] key_down;
  mode_t mode;
  logic [2:0] filter_sel, fs;
  logic split_upper, meter_af, manual_gain, tune_lock, beat_osc_tune, beat_osc_centred;
  logic remote_ctl, entry_active, beat_osc_below, fault_lamp, m;
  agc_t agc_mode;
  rate_t tune_rate;
  logic [24:0] freq_hz, f0, s;
  logic signed [15:0] beat_osc_hz;
  logic [3:0] seen = 4'h0;
  int err_total = 0;
  int check_count = 0;
  row_t rows [0:19] = '{
    '{K_UPPER_SB, 19'h0003F, 19'h00002},
    '{K_LOWER_SB, 19'h0003F, 19'h0000B},
    '{K_AMPLITUDE, 19'h00007, 19'h00000},
    '{K_NARROWEST_FILTER + 4, 19'h00038, 19'h00030},
    '{K_NARROWEST_FILTER, 19'h00038, 19'h00010},
    '{K_METER_SCALE, 19'h00080, 19'h00080},
    '{K_METER_SCALE, 19'h00080, 19'h00000},
    '{K_MANUAL_GAIN, 19'h00700, 19'h00300},
    '{K_SHORT_AGC, 19'h00700, 19'h00100},
    '{K_MANUAL_GAIN, 19'h00700, 19'h00200},
    '{K_MANUAL_GAIN, 19'h00700, 19'h00300},
    '{K_SHORT_AGC + 1, 19'h00700, 19'h00500},
    '{K_MANUAL_GAIN, 19'h00700, 19'h00400},
    '{K_BEAT_OSC, 19'h04000, 19'h00000},
    '{K_SPLIT, 19'h00007, 19'h00000},
    '{K_LOCAL_REMOTE, 19'h10000, 19'h10000},
    '{K_METER_SCALE, 19'h10080, 19'h10000},
    '{K_LOCAL_REMOTE, 19'h10000, 19'h00000},
    '{K_FREQ_MOD, 19'h00007, 19'h00005},
    '{K_SHORT_AGC + 2, 19'h00700, 19'h00600}};

  // bus slave tied selected; hready follows the slave's own ready
  front_panel_control #(.DEB_CYC(4), .SPIN_CYC(20), .NUM_SYNTH(3)) uut (
    .hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .key_down(key_down),
    .enc_a(enc_a), .enc_b(enc_b), .synth_unlock(synth_unlock), .mode(mode),
    .filter_sel(filter_sel), .split_upper(split_upper), .meter_af(meter_af),
    .manual_gain(manual_gain), .agc_mode(agc_mode), .tune_rate(tune_rate),
    .tune_lock(tune_lock), .beat_osc_tune(beat_osc_tune),
    .beat_osc_centred(beat_osc_centred), .remote_ctl(remote_ctl),
    .entry_active(entry_active), .freq_hz(freq_hz), .beat_osc_hz(beat_osc_hz),
    .beat_osc_below(beat_osc_below), .fault_lamp(fault_lamp)
  );
  panel_model pm (.key_down(key_down), .enc_a(enc_a), .enc_b(enc_b), .hclk(hclk));

  // 50 MHz clock
  always #10 hclk = ~hclk;

  // single word transfer; read data taken at the edge that ends the data phase
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd);
    @(posedge hclk);
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : bus
  task automatic st(input logic [18:0] msk, input logic [18:0] e);
    bus(1'b0, ADDR_STATUS, 32'h00000000);
    `CHK(rd[18:0] & msk, e)
  endtask : st
  // encoder step size per rate, as the operator sees it
  function automatic logic [24:0] step(input rate_t t);
    return t == RATE_SLOW ? 25'h000001E : t == RATE_FAST ? 25'h00003E8 : 25'h0000001;
  endfunction : step
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : end_of_test

  // hang guard, well beyond the expected run length
  initial begin
    repeat (30000) @(posedge hclk);
    err_total++;
    end_of_test();
  end

  // main sequence
  initial begin
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    st(19'h7FFFF, 19'h00250);
    bus(1'b0, ADDR_CONFIG, 32'h00000000);
    `CHK(rd, 32'h00000050)
    bus(1'b0, 32'h00000010, 32'h00000000);
    `CHK({rd, hresp, hreadyout}, 34'h000000001)
    $display("test reset done");
    foreach (rows[i]) begin
      pm.press(rows[i].k, 8);
      st(rows[i].m, rows[i].e);
    end
    `CHK({manual_gain, agc_mode, remote_ctl, mode}, {1'b0, AGC_LONG, 1'b0, MODE_FREQ_MOD})
    $display("test key table done");
    pm.turn(1'b0, 30);
    `CHK(freq_hz, 25'h0000000)
    pm.turn(1'b1, 30);
    `CHK(freq_hz, 25'h0000001)
    for (int i = 0; i < 3; i++) begin
      pm.press(K_TUNE_RATE, 8);
      seen[tune_rate] = 1'b1;
      f0 = freq_hz;
      pm.turn(1'b1, 30);
      `CHK(freq_hz, f0 + step(tune_rate))
    end
    `CHK(seen, 4'h7)
    f0 = freq_hz;
    s = step(tune_rate);
    pm.turn(1'b1, 2);
    pm.turn(1'b1, 30);
    `CHK(freq_hz, f0 + 25'h0000009 * s)
    pm.press(K_LOCK, 8);
    f0 = freq_hz;
    pm.turn(1'b1, 30);
    `CHK({tune_lock, freq_hz}, {1'b1, f0})
    pm.press(K_TUNE_RATE, 8);
    `CHK(tune_lock, 1'b0)
    $display("test tuning done");
    pm.press(K_LOCK, 8);
    pm.press(K_CONT_WAVE, 8);
    pm.press(K_BEAT_OSC, 8);
    `CHK({tune_lock, beat_osc_tune}, 2'h1)
    f0 = freq_hz;
    s = step(tune_rate);
    pm.turn(1'b0, 30);
    `CHK({freq_hz, beat_osc_below}, {f0, 1'b1})
    `CHK(beat_osc_hz, 16'h0000 - s[15:0])
    bus(1'b0, ADDR_BEAT_OSC, 32'h00000000);
    `CHK(rd, 32'h00000000 - {7'h00, s})
    pm.press(K_BEAT_OSC_CENTRE, 8);
    `CHK({beat_osc_centred, beat_osc_hz}, 17'h10000)
    pm.press(K_LOCK, 8);
    pm.press(K_BEAT_OSC, 8);
    `CHK(tune_lock, 1'b1)
    pm.press(K_BEAT_OSC_CENTRE, 8);
    `CHK({beat_osc_centred, beat_osc_hz}, {1'b0, 16'h0000 - s[15:0]})
    $display("test beat oscillator done");
    pm.press(K_TUNE_RATE, 8);
    f0 = freq_hz;
    pm.press(K_DIGIT0 + 7, 8);
    `CHK({entry_active, freq_hz}, {1'b0, f0})
    pm.press(K_ENTER, 8);
    pm.press(K_DIGIT0 + 1, 8);
    pm.press(K_DIGIT0 + 2, 8);
    pm.press(K_ENTER, 8);
    `CHK({entry_active, freq_hz}, {1'b0, 25'h0B71B00})
    pm.press(K_ENTER, 8);
    pm.press(K_DIGIT0 + 3, 8);
    pm.press(K_DIGIT0, 8);
    pm.press(K_DIGIT0 + 5, 8);
    pm.press(K_ENTER, 8);
    `CHK(freq_hz, 25'h04C4B40)
    $display("test keypad done");
    @(posedge hclk);
    synth_unlock <= 3'h2;
    repeat (3) @(posedge hclk);
    `CHK(fault_lamp, 1'b1)
    st(19'h40000, 19'h40000);
    synth_unlock <= 3'h0;
    repeat (3) @(posedge hclk);
    `CHK(fault_lamp, 1'b0)
    bus(1'b1, ADDR_CONFIG, 32'h00000031);
    bus(1'b0, ADDR_CONFIG, 32'h00000000);
    `CHK(rd, 32'h00000031)
    fs = filter_sel;
    pm.press(K_NARROWEST_FILTER + 3, 8);
    `CHK(filter_sel, fs)
    pm.press(K_NARROWEST_FILTER + 2, 8);
    `CHK(filter_sel, 3'h4)
    pm.press(K_SPLIT, 8);
    `CHK({mode, split_upper}, {MODE_INDEP_SB, 1'b1})
    pm.press(K_SPLIT, 8);
    `CHK({mode, split_upper}, {MODE_INDEP_SB, 1'b0})
    m = meter_af;
    pm.press(K_METER_SCALE, 40);
    `CHK(meter_af, ~m)
    $display("test options and faults done");
    end_of_test();
  end
endmodule : receiver_front_panel_control_test
